// >>> fsr_pkg.sv
package fsr_pkg;
    // apdu header bytes
    localparam logic [7:0] CLA_ISO = 8'h00;
    localparam logic [7:0] INS_SELECT = 8'hA4;
    localparam logic [7:0] INS_READ = 8'hB0;
    localparam logic [7:0] SEL_P1 = 8'h00;
    localparam logic [7:0] SEL_P2 = 8'h0C;
    localparam logic [7:0] SEL_LC = 8'h02;
    // file identifiers
    localparam logic [15:0] FID_CC = 16'hE103;
    localparam logic [15:0] FID_SYS = 16'hE101;
    localparam logic [15:0] FID_NDEF1 = 16'h0001;
    localparam logic [11:0] FID_NDEF_HI = 12'h000;
    // status words
    localparam logic [15:0] SW_OK = 16'h9000;
    localparam logic [15:0] SW_NOT_FOUND = 16'h6A82;
    localparam logic [15:0] SW_INS_BAD = 16'h6D00;
    localparam logic [15:0] SW_CLA_BAD = 16'h6E00;
    localparam logic [15:0] SW_WRONG_LEN = 16'h6700;
    localparam logic [15:0] SW_DENIED = 16'h6982;
    localparam logic [7:0] SW1_OK = 8'h90;
    localparam logic [7:0] SW2_READ = 8'h00;
    // read length bounds
    localparam logic [7:0] LE_MIN = 8'h01;
    localparam logic [7:0] LE_CAP = 8'hF6;
    // reset values
    localparam logic [1:0] CUR_NONE_RST = 2'h0;
    // current file codes
    typedef enum logic [1:0] {
        FSR_F_NONE = 2'h0,
        FSR_F_CC = 2'h1,
        FSR_F_NDEF = 2'h2,
        FSR_F_SYS = 2'h3
    } fsr_file_t;
    // interpreter states, gray along the usual path
    typedef enum logic [2:0] {
        FSR_S_IDLE = 3'b000,
        FSR_S_HDR = 3'b001,
        FSR_S_BODY = 3'b011,
        FSR_S_EXEC = 3'b010,
        FSR_S_FETCH = 3'b110,
        FSR_S_DATA = 3'b111,
        FSR_S_SW1 = 3'b101,
        FSR_S_SW2 = 3'b100
    } fsr_state_t;
endpackage

// >>> fsr_port_mux.sv
// picks one of the two links per command; first requester wins, held until frame end
module fsr_port_mux (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // contactless side
    input wire logic i_rf_valid,
    input wire logic [7:0] i_rf_data,
    input wire logic i_rf_last,
    // i2c side
    input wire logic i_i2c_valid,
    input wire logic [7:0] i_i2c_data,
    input wire logic i_i2c_last,
    // merged stream
    output logic o_valid,
    output logic [7:0] o_data,
    output logic o_last,
    output logic o_src_i2c
);
    logic busy_q, busy_d, src_q, src_d, sel;

    always_comb begin
        sel = busy_q ? src_q : (!i_rf_valid && i_i2c_valid);
        busy_d = busy_q;
        src_d = src_q;
        o_valid = sel ? i_i2c_valid : i_rf_valid;
        o_data = sel ? i_i2c_data : i_rf_data;
        o_last = sel ? i_i2c_last : i_rf_last;
        if (o_valid) begin
            busy_d = !o_last;
            src_d = sel;
        end
        o_src_i2c = sel;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            busy_q <= 1'b0;
            src_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
            src_q <= src_d;
        end
    end
endmodule

// >>> fsr_apdu_core.sv
// Operation
// - select of cc file: 00 A4 00 0C 02 E103, no le
// - cc file becomes current only with 9000 answer
// - cc select answers 6A82 if missing, 6D00 on bad class
// - ndef select same header, data 000X is file number, 0001 first
// - ndef file current only on success; 6A82 when file absent
// - new ndef select revokes earlier password access rights
// - system file select: 00 A4 00 0C 02 E101
// - system file current only on success; 6A82 with no data otherwise
// - read: 00 B0, offset in p1-p2, one le byte; returns bytes
// - read succeeds only if offset plus le within file length
// - read success sends data then 90, second byte don't care
// - read failures answer 6700, 6982, 6A82 or 6E00
// - every answer ends in two status bytes; 9000 is success
// - same commands accepted from contactless and i2c links
module fsr_apdu_core #(
    parameter int NDEF_FILES = 1,
    parameter int AW = 16
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // command streams, one byte per valid cycle
    input wire logic i_rf_valid,
    input wire logic [7:0] i_rf_data,
    input wire logic i_rf_last,
    input wire logic i_i2c_valid,
    input wire logic [7:0] i_i2c_data,
    input wire logic i_i2c_last,
    // file lengths and protection, from memory management
    input wire logic [15:0] i_cc_len,
    input wire logic [15:0] i_ndef_len,
    input wire logic [15:0] i_sys_len,
    input wire logic i_ndef_rd_locked,
    input wire logic i_ndef_rd_granted,
    // memory read port, data taken in the same cycle as the request strobe
    output logic o_mem_rd,
    output logic [1:0] o_mem_file,
    output logic [AW-1:0] o_mem_addr,
    input wire logic [7:0] i_mem_data,
    // response stream
    output logic o_rsp_valid,
    output logic [7:0] o_rsp_data,
    output logic o_rsp_last,
    output logic o_rsp_i2c,
    input wire logic i_rsp_ready,
    // status
    output logic o_busy,
    output logic o_revoke_access,
    output logic [1:0] o_cur_file
);
    fsr_pkg::fsr_state_t st_q, st_d;
    logic m_valid, m_last, m_i2c;
    logic [7:0] m_data;
    logic [7:0] hdr_q [0:6];
    logic [7:0] hdr_d [0:6];
    logic [2:0] cnt_q, cnt_d;
    logic bad_q, bad_d;
    logic i2c_q, i2c_d;
    logic [1:0] cur_q, cur_d;
    logic [15:0] sw_q, sw_d;
    logic [7:0] left_q, left_d;
    logic [AW-1:0] addr_q, addr_d;
    logic rd_q, rd_d;
    logic rv_q, rv_d;
    logic [7:0] rdat_q, rdat_d;
    logic rlast_q, rlast_d;
    logic revoke_q, revoke_d;
    logic [15:0] flen;
    logic [16:0] span;
    logic busy_q, busy_d;
    logic [15:0] fid;

    function automatic logic [15:0] file_len(input logic [1:0] f, input logic [15:0] c,
                                             input logic [15:0] n, input logic [15:0] s);
        case (f)
            fsr_pkg::FSR_F_CC: file_len = c;
            fsr_pkg::FSR_F_NDEF: file_len = n;
            fsr_pkg::FSR_F_SYS: file_len = s;
            default: file_len = 16'h0000;
        endcase
    endfunction

    // exact seven-byte select frame; class is judged apart for its own status word
    function automatic logic sel_shape_ok(input logic b, input logic [2:0] n, input logic [7:0] p1,
                                          input logic [7:0] p2, input logic [7:0] lc);
        sel_shape_ok = !b && n == 3'h7 && p1 == fsr_pkg::SEL_P1 && p2 == fsr_pkg::SEL_P2 &&
                       lc == fsr_pkg::SEL_LC;
    endfunction

    // zero le or a window past the file end is a length fault
    function automatic logic rd_len_ok(input logic b, input logic [2:0] n, input logic [7:0] le,
                                       input logic [16:0] end_pos, input logic [15:0] len);
        rd_len_ok = !b && n == 3'h5 && le >= fsr_pkg::LE_MIN && end_pos <= {1'b0, len};
    endfunction

    // file numbers 1..NDEF_FILES under the all-zero prefix
    function automatic logic ndef_fid_ok(input logic [15:0] fid_in);
        ndef_fid_ok = fid_in[15:4] == fsr_pkg::FID_NDEF_HI && fid_in[3:0] != 4'h0 &&
                      {28'h0, fid_in[3:0]} <= NDEF_FILES;
    endfunction

    fsr_port_mux u_mux (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_rf_valid(i_rf_valid),
        .i_rf_data(i_rf_data),
        .i_rf_last(i_rf_last),
        .i_i2c_valid(i_i2c_valid),
        .i_i2c_data(i_i2c_data),
        .i_i2c_last(i_i2c_last),
        .o_valid(m_valid),
        .o_data(m_data),
        .o_last(m_last),
        .o_src_i2c(m_i2c)
    );

    // length bound of whichever file is current
    assign flen = file_len(cur_q, i_cc_len, i_ndef_len, i_sys_len);
    // one bit wider so offset plus le cannot wrap
    assign span = {hdr_q[2], hdr_q[3]} + {9'h000, hdr_q[4]};
    assign fid = {hdr_q[5], hdr_q[6]};

    always_comb begin
        st_d = st_q;
        hdr_d = hdr_q;
        cnt_d = cnt_q;
        bad_d = bad_q;
        i2c_d = i2c_q;
        cur_d = cur_q;
        sw_d = sw_q;
        left_d = left_q;
        addr_d = addr_q;
        // strobe is a one-cycle pulse
        rd_d = 1'b0;
        rv_d = rv_q;
        rdat_d = rdat_q;
        rlast_d = rlast_q;
        revoke_d = 1'b0;
        if (rv_q && i_rsp_ready) begin
            rv_d = 1'b0;
        end
        case (st_q)
            fsr_pkg::FSR_S_IDLE: begin
                cnt_d = 3'h0;
                bad_d = 1'b0;
                if (m_valid) begin
                    hdr_d[0] = m_data;
                    cnt_d = 3'h1;
                    i2c_d = m_i2c;
                    st_d = m_last ? fsr_pkg::FSR_S_EXEC : fsr_pkg::FSR_S_HDR;
                    // a one-byte frame is too short for any command
                    bad_d = m_last;
                end
            end
            fsr_pkg::FSR_S_HDR, fsr_pkg::FSR_S_BODY: begin
                // frames longer than seven bytes are flagged and answered as wrong
                if (m_valid) begin
                    if (cnt_q == 3'h7) begin
                        bad_d = 1'b1;
                    end else begin
                        hdr_d[cnt_q] = m_data;
                        cnt_d = cnt_q + 3'h1;
                    end
                    st_d = fsr_pkg::FSR_S_BODY;
                    if (m_last) begin
                        st_d = fsr_pkg::FSR_S_EXEC;
                    end
                end
            end
            fsr_pkg::FSR_S_EXEC: begin
                st_d = fsr_pkg::FSR_S_SW1;
                left_d = 8'h00;
                if (hdr_q[1] == fsr_pkg::INS_SELECT) begin
                    if (hdr_q[0] != fsr_pkg::CLA_ISO) begin
                        sw_d = fsr_pkg::SW_INS_BAD;
                    end else if (!sel_shape_ok(bad_q, cnt_q, hdr_q[2], hdr_q[3], hdr_q[4])) begin
                        sw_d = fsr_pkg::SW_NOT_FOUND;
                    end else if (fid == fsr_pkg::FID_CC) begin
                        sw_d = fsr_pkg::SW_OK;
                        cur_d = fsr_pkg::FSR_F_CC;
                    end else if (fid == fsr_pkg::FID_SYS) begin
                        sw_d = fsr_pkg::SW_OK;
                        cur_d = fsr_pkg::FSR_F_SYS;
                    end else if (ndef_fid_ok(fid)) begin
                        sw_d = fsr_pkg::SW_OK;
                        cur_d = fsr_pkg::FSR_F_NDEF;
                        revoke_d = 1'b1;
                    end else begin
                        // failed select keeps the previous current file
                        sw_d = fsr_pkg::SW_NOT_FOUND;
                    end
                end else if (hdr_q[1] == fsr_pkg::INS_READ) begin
                    if (hdr_q[0] != fsr_pkg::CLA_ISO) begin
                        sw_d = fsr_pkg::SW_CLA_BAD;
                    end else if (cur_q == fsr_pkg::FSR_F_NONE) begin
                        sw_d = fsr_pkg::SW_NOT_FOUND;
                    end else if (!rd_len_ok(bad_q, cnt_q, hdr_q[4], span, flen)) begin
                        sw_d = fsr_pkg::SW_WRONG_LEN;
                    end else if (cur_q == fsr_pkg::FSR_F_NDEF && i_ndef_rd_locked &&
                                 !i_ndef_rd_granted) begin
                        sw_d = fsr_pkg::SW_DENIED;
                    end else begin
                        sw_d = {fsr_pkg::SW1_OK, fsr_pkg::SW2_READ};
                        left_d = hdr_q[4];
                        addr_d = AW'({hdr_q[2], hdr_q[3]});
                        st_d = fsr_pkg::FSR_S_FETCH;
                    end
                end else begin
                    sw_d = hdr_q[0] != fsr_pkg::CLA_ISO ? fsr_pkg::SW_CLA_BAD : fsr_pkg::SW_INS_BAD;
                end
            end
            fsr_pkg::FSR_S_FETCH: begin
                // one byte in flight: memory answers in the cycle the strobe stands
                if (!rv_q || i_rsp_ready) begin
                    rd_d = 1'b1;
                    st_d = fsr_pkg::FSR_S_DATA;
                end
            end
            fsr_pkg::FSR_S_DATA: begin
                rv_d = 1'b1;
                rdat_d = i_mem_data;
                rlast_d = 1'b0;
                addr_d = addr_q + AW'(1);
                left_d = left_q - 8'h01;
                st_d = (left_q == 8'h01) ? fsr_pkg::FSR_S_SW1 : fsr_pkg::FSR_S_FETCH;
            end
            fsr_pkg::FSR_S_SW1: begin
                if (!rv_q || i_rsp_ready) begin
                    rv_d = 1'b1;
                    rdat_d = sw_q[15:8];
                    rlast_d = 1'b0;
                    st_d = fsr_pkg::FSR_S_SW2;
                end
            end
            fsr_pkg::FSR_S_SW2: begin
                if (!rv_q || i_rsp_ready) begin
                    rv_d = 1'b1;
                    rdat_d = sw_q[7:0];
                    // links are free again from the next cycle, while this byte may still wait to be taken
                    rlast_d = 1'b1;
                    st_d = fsr_pkg::FSR_S_IDLE;
                end
            end
            default: st_d = fsr_pkg::FSR_S_IDLE;
        endcase
        // held until the last status byte is taken; idle still accepts a new frame meanwhile
        busy_d = (st_d != fsr_pkg::FSR_S_IDLE) || rv_d;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_q <= fsr_pkg::FSR_S_IDLE;
            for (int k = 0; k < 7; k++) begin
                hdr_q[k] <= 8'h00;
            end
            cnt_q <= 3'h0;
            bad_q <= 1'b0;
            i2c_q <= 1'b0;
            cur_q <= fsr_pkg::CUR_NONE_RST;
            sw_q <= 16'h0000;
            left_q <= 8'h00;
            addr_q <= '0;
            rd_q <= 1'b0;
            rv_q <= 1'b0;
            rdat_q <= 8'h00;
            rlast_q <= 1'b0;
            revoke_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            hdr_q <= hdr_d;
            cnt_q <= cnt_d;
            bad_q <= bad_d;
            i2c_q <= i2c_d;
            cur_q <= cur_d;
            sw_q <= sw_d;
            left_q <= left_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
            rv_q <= rv_d;
            rdat_q <= rdat_d;
            rlast_q <= rlast_d;
            revoke_q <= revoke_d;
            busy_q <= busy_d;
        end
    end

    assign o_mem_rd = rd_q;
    assign o_mem_file = cur_q;
    assign o_mem_addr = addr_q;
    assign o_rsp_valid = rv_q;
    assign o_rsp_data = rdat_q;
    assign o_rsp_last = rlast_q;
    assign o_rsp_i2c = i2c_q;
    assign o_busy = busy_q;
    assign o_revoke_access = revoke_q;
    assign o_cur_file = cur_q;
endmodule

// >>> fsr_apdu_checker.sv
module fsr_apdu_checker (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // command side
    input wire logic i_rf_valid,
    input wire logic i_rf_last,
    input wire logic i_i2c_valid,
    input wire logic i_i2c_last,
    // memory and response side
    input wire logic o_mem_rd,
    input wire logic [1:0] o_mem_file,
    input wire logic o_rsp_valid,
    input wire logic [7:0] o_rsp_data,
    input wire logic o_rsp_last,
    input wire logic i_rsp_ready,
    // status
    input wire logic o_busy,
    input wire logic o_revoke_access,
    input wire logic [1:0] o_cur_file
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_frame_end;
        (i_rf_valid && i_rf_last) || (i_i2c_valid && i_i2c_last);
    endsequence
    sequence s_last_taken;
        o_rsp_valid && o_rsp_last && i_rsp_ready;
    endsequence
    property p_rsp_hold;
        o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_data) && $stable(o_rsp_last);
    endproperty
    a_rsp_hold: assert property (p_rsp_hold) else $error("response byte moved while stalled");
    property p_end_idle;
        s_last_taken |=> !o_busy && !o_rsp_valid;
    endproperty
    a_end_idle: assert property (p_end_idle) else $error("not idle after final status byte");
    property p_answer;
        s_frame_end |=> o_busy ##[1:40] o_rsp_valid;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer after command frame");
    property p_quiet;
        !o_busy |-> !o_rsp_valid;
    endproperty
    a_quiet: assert property (p_quiet) else $error("response while idle");
    property p_mem_rd;
        o_mem_rd |-> o_cur_file != fsr_pkg::FSR_F_NONE && o_mem_file == o_cur_file;
    endproperty
    a_mem_rd: assert property (p_mem_rd) else $error("read not from current file");
    property p_mem_pulse;
        o_mem_rd |=> !o_mem_rd ##[0:4] o_rsp_valid;
    endproperty
    a_mem_pulse: assert property (p_mem_pulse) else $error("memory read not forwarded");
    property p_cur_change;
        $changed(o_cur_file) |=> o_rsp_valid && o_rsp_data == fsr_pkg::SW1_OK;
    endproperty
    a_cur_change: assert property (p_cur_change) else $error("current file moved without success");
    property p_revoke;
        o_revoke_access |=> !o_revoke_access ##[0:3] o_cur_file == fsr_pkg::FSR_F_NDEF;
    endproperty
    a_revoke: assert property (p_revoke) else $error("revoke without ndef selection");
endmodule

// >>> fsr_mem_model.sv
// file memory; byte depends on file and offset so misplaced reads show up
module fsr_mem_model (
    input wire logic i_core_clk,
    input wire logic i_mem_rd,
    input wire logic [1:0] i_mem_file,
    input wire logic [15:0] i_mem_addr,
    output logic [7:0] o_mem_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] noise_q = 8'h00;
    // the core takes the byte while its strobe stands; off the strobe the pattern flips
    always @(posedge i_core_clk) begin
        noise_q <= ~noise_q;
    end
    assign o_mem_data = i_mem_rd ? ({i_mem_file, i_mem_addr[5:0]} ^ 8'h5A) : noise_q;
endmodule

// >>> testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {bit rf; int n; logic [7:0] b[8]; logic [15:0] sw; logic [1:0] cur; int nd;} fsr_row_t;
    logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_rsp_ready = 1'b0;
    logic i_rf_valid = 1'b0, i_rf_last = 1'b0, i_i2c_valid = 1'b0, i_i2c_last = 1'b0;
    logic i_ndef_rd_locked = 1'b0, i_ndef_rd_granted = 1'b0;
    logic [7:0] i_rf_data = 8'h00, i_i2c_data = 8'h00, i_mem_data, o_rsp_data;
    logic [15:0] i_cc_len = 16'h000F, i_ndef_len = 16'h0020, i_sys_len = 16'h0012, o_mem_addr;
    logic o_mem_rd, o_rsp_valid, o_rsp_last, o_rsp_i2c, o_busy, o_revoke_access, got_i2c;
    logic [1:0] o_mem_file, o_cur_file;
    logic [7:0] got[$], exp_q[$];
    int fail_count = 0, samples_checked = 0;
    int revokes = 0;
    fsr_row_t rows[13] = '{
        '{1, 5, '{8'h00, 8'hB0, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00}, 16'h6A82, 2'h0, 0},
        '{1, 7, '{8'h00, 8'hA4, 8'h00, 8'h0C, 8'h02, 8'hE1, 8'h03, 8'h00}, 16'h9000, 2'h1, 0},
        '{0, 5, '{8'h00, 8'hB0, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h00}, 16'h9000, 2'h1, 15},
        '{1, 5, '{8'h00, 8'hB0, 8'h00, 8'h01, 8'h0F, 8'h00, 8'h00, 8'h00}, 16'h6700, 2'h1, 0},
        '{1, 7, '{8'h01, 8'hA4, 8'h00, 8'h0C, 8'h02, 8'hE1, 8'h03, 8'h00}, 16'h6D00, 2'h1, 0},
        '{0, 5, '{8'h01, 8'hB0, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00}, 16'h6E00, 2'h1, 0},
        '{1, 5, '{8'h00, 8'hCA, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00}, 16'h6D00, 2'h1, 0},
        '{0, 7, '{8'h00, 8'hA4, 8'h00, 8'h0C, 8'h02, 8'hE1, 8'h01, 8'h00}, 16'h9000, 2'h3, 0},
        '{1, 5, '{8'h00, 8'hB0, 8'h00, 8'h10, 8'h02, 8'h00, 8'h00, 8'h00}, 16'h9000, 2'h3, 2},
        '{1, 7, '{8'h00, 8'hA4, 8'h00, 8'h0C, 8'h02, 8'hE1, 8'h05, 8'h00}, 16'h6A82, 2'h3, 0},
        '{0, 7, '{8'h00, 8'hA4, 8'h00, 8'h0C, 8'h02, 8'h00, 8'h02, 8'h00}, 16'h6A82, 2'h3, 0},
        '{1, 8, '{8'h00, 8'hA4, 8'h00, 8'h0C, 8'h02, 8'hE1, 8'h03, 8'h00}, 16'h6A82, 2'h3, 0},
        '{0, 7, '{8'h00, 8'hA4, 8'h00, 8'h0C, 8'h02, 8'h00, 8'h01, 8'h00}, 16'h9000, 2'h2, 0}
    };
    fsr_apdu_core #(.NDEF_FILES(1), .AW(16)) dut (.i_core_clk, .i_rst_n, .i_rf_valid, .i_rf_data, .i_rf_last,
        .i_i2c_valid, .i_i2c_data, .i_i2c_last, .i_cc_len, .i_ndef_len, .i_sys_len, .i_ndef_rd_locked,
        .i_ndef_rd_granted, .o_mem_rd, .o_mem_file, .o_mem_addr, .i_mem_data, .o_rsp_valid, .o_rsp_data,
        .o_rsp_last, .o_rsp_i2c, .i_rsp_ready, .o_busy, .o_revoke_access, .o_cur_file);
    fsr_mem_model mem (.i_core_clk, .i_mem_rd(o_mem_rd), .i_mem_file(o_mem_file), .i_mem_addr(o_mem_addr),
        .o_mem_data(i_mem_data));
    initial begin
        forever #2.5 i_core_clk = ~i_core_clk;
    end
    always @(negedge i_core_clk) begin
        if (o_revoke_access === 1'b1) begin
            revokes++;
        end
    end
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task summarize;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task run(input fsr_row_t r);
        int t;
        bit done;
        t = 0;
        done = 1'b0;
        exp_q = {};
        got = {};
        for (int i = 0; i < r.nd; i++) begin
            exp_q.push_back({r.cur, 6'({r.b[2], r.b[3]} + i)} ^ 8'h5A);
        end
        exp_q.push_back(r.sw[15:8]);
        exp_q.push_back(r.sw[7:0]);
        for (int i = 0; i < r.n; i++) begin
            @(negedge i_core_clk);
            i_rf_valid = r.rf;
            i_i2c_valid = !r.rf;
            i_rf_data = r.b[i];
            i_i2c_data = r.b[i];
            i_rf_last = (i == r.n - 1);
            i_i2c_last = (i == r.n - 1);
        end
        @(negedge i_core_clk);
        i_rf_valid = 1'b0;
        i_i2c_valid = 1'b0;
        // ready stalls one cycle in three to exercise the hold
        while (t < 400) begin
            @(negedge i_core_clk);
            t++;
            i_rsp_ready = (t % 3 != 0);
            if (o_rsp_valid === 1'b1 && i_rsp_ready) begin
                got.push_back(o_rsp_data);
                got_i2c = o_rsp_i2c;
                if (o_rsp_last === 1'b1) begin
                    done = 1'b1;
                    break;
                end
            end
        end
        chk("rsp_done", {15'h0000, done}, 16'h0001);
        chk("rsp_len", 16'(got.size()), 16'(exp_q.size()));
        for (int i = 0; i < got.size() && i < exp_q.size(); i++) begin
            chk("rsp_byte", {8'h00, got[i]}, {8'h00, exp_q[i]});
        end
        chk("rsp_link", {15'h0000, got_i2c}, {15'h0000, !r.rf});
        chk("cur_file", {14'h0000, o_cur_file}, {14'h0000, r.cur});
    endtask
    initial begin
        repeat (4) @(negedge i_core_clk);
        chk("busy_rst", {15'h0000, o_busy}, 16'h0000);
        chk("cur_rst", {14'h0000, o_cur_file}, 16'h0000);
        i_rst_n = 1'b1;
        foreach (rows[k]) begin
            run(rows[k]);
        end
        chk("revoke_cnt", 16'(revokes), 16'h0001);
        i_ndef_rd_locked = 1'b1;
        run('{1, 5, '{8'h00, 8'hB0, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00}, 16'h6982, 2'h2, 0});
        i_ndef_rd_granted = 1'b1;
        run('{0, 5, '{8'h00, 8'hB0, 8'h00, 8'h1C, 8'h04, 8'h00, 8'h00, 8'h00}, 16'h9000, 2'h2, 4});
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_core_clk);
        chk("cur_rerst", {14'h0000, o_cur_file}, 16'h0000);
        i_rst_n = 1'b1;
        run('{0, 5, '{8'h00, 8'hB0, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00}, 16'h6A82, 2'h0, 0});
        summarize;
    end
    initial begin
        #100000;
        fail_count++;
        summarize;
    end
endmodule
bind fsr_apdu_core fsr_apdu_checker chk_i (.i_core_clk, .i_rst_n, .i_rf_valid, .i_rf_last, .i_i2c_valid,
    .i_i2c_last, .o_mem_rd, .o_mem_file, .o_rsp_valid, .o_rsp_data, .o_rsp_last, .i_rsp_ready, .o_busy,
    .o_revoke_access, .o_cur_file);
